/* File: rtl/mirq_top.sv */
// interrupt request logic with apb register access
`timescale 1ns/1ps
`default_nettype none
module mirq_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext0_pin,
    input wire logic ext1_pin,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic vector_ack,
    output logic vector_req,
    output logic [11:0] vector_addr,
    output logic [2:0] stack_level,
    output logic irq
);
    logic [7:0] flag_q;
    logic [7:0] flag_d;
    logic [7:0] ien_q;
    logic gie_q;
    logic [1:0] edge_q;
    logic [3:0] st_q;
    logic [3:0] st_d;
    logic [3:0] st_en_q;
    logic [2:0] stack_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic vreq_q;
    logic irq_q;
    mirq_pkg::mirq_state_t state_q;
    mirq_pkg::mirq_state_t state_d;
    logic e0_hit;
    logic e1_hit;
    logic t0_s1_q;
    logic t0_s2_q;
    logic t1_s1_q;
    logic t1_s2_q;
    logic t0_prev_q;
    logic t1_prev_q;

    function automatic logic hit_at(input logic [11:0] a, input logic [11:0] off);
        hit_at = (a == off);
    endfunction

    // apb decode
    wire acc = psel & penable & ~pready_q & clk_en;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire a_flag = hit_at(paddr, mirq_pkg::MIRQ_OFF_FLAG);
    wire a_ien = hit_at(paddr, mirq_pkg::MIRQ_OFF_IEN);
    wire a_ctrl = hit_at(paddr, mirq_pkg::MIRQ_OFF_CTRL);
    wire a_stat = hit_at(paddr, mirq_pkg::MIRQ_OFF_STAT);
    wire a_sten = hit_at(paddr, mirq_pkg::MIRQ_OFF_ST_EN);
    wire a_stclr = hit_at(paddr, mirq_pkg::MIRQ_OFF_ST_CLR);
    wire a_stack = hit_at(paddr, mirq_pkg::MIRQ_OFF_STACK);
    wire mapped = a_flag | a_ien | a_ctrl | a_stat | a_sten | a_stclr | a_stack;

    // external edge detectors; ext1 is fixed falling
    mirq_edge u_ext0 (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .sig_in(ext0_pin),
        .mode(edge_q),
        .hit(e0_hit)
    );
    mirq_edge u_ext1 (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .sig_in(ext1_pin),
        .mode(mirq_pkg::MIRQ_EDGE_FALL),
        .hit(e1_hit)
    );

    // timer overflow inputs arrive from another block's pins; sync then take rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_s1_q <= 1'b0;
            t0_s2_q <= 1'b0;
            t0_prev_q <= 1'b0;
            t1_s1_q <= 1'b0;
            t1_s2_q <= 1'b0;
            t1_prev_q <= 1'b0;
        end else if (clk_en) begin
            t0_s1_q <= timer0_ovf;
            t0_s2_q <= t0_s1_q;
            t0_prev_q <= t0_s2_q;
            t1_s1_q <= timer1_ovf;
            t1_s2_q <= t1_s1_q;
            t1_prev_q <= t1_s2_q;
        end
    end
    wire t0_hit = clk_en & t0_s2_q & ~t0_prev_q;
    wire t1_hit = clk_en & t1_s2_q & ~t1_prev_q;

    // event vector in flag layout; enables play no part here
    wire [7:0] ev = {1'b0, t1_hit, 1'b0, t0_hit, 2'b00, e1_hit, e0_hit};

    // software write first, then events override so a set wins over a clear
    assign flag_d = ((wr & a_flag) ? (pwdata[7:0] & mirq_pkg::MIRQ_FLAG_MASK) : flag_q) | ev;

    // pending request: enabled flag under global enable
    wire [7:0] pend_vec = flag_q & ien_q;
    wire pend = gie_q & (|pend_vec);

    // entry sequencer: request held until the core acknowledges
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            mirq_pkg::MIRQ_IDLE: if (pend) state_d = mirq_pkg::MIRQ_ENTRY;
            mirq_pkg::MIRQ_ENTRY: if (vector_ack) state_d = mirq_pkg::MIRQ_WAIT;
            mirq_pkg::MIRQ_WAIT: state_d = mirq_pkg::MIRQ_IDLE;
            default: state_d = mirq_pkg::MIRQ_IDLE;
        endcase
    end
    wire take = (state_q == mirq_pkg::MIRQ_ENTRY) & vector_ack & clk_en;

    // block status: entry taken, any timer event, any external event, request pending
    assign st_d = (st_q & ~((wr & a_stclr) ? pwdata[3:0] : 4'h0)) | {take, |ev[7:4], |ev[1:0], pend};

    // flags and enables; global enable changes only on a control write and stays set across entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 8'h00;
            ien_q <= 8'h00;
            gie_q <= 1'b0;
            edge_q <= mirq_pkg::MIRQ_EDGE_RST;
        end else if (clk_en) begin
            flag_q <= flag_d;
            if (wr & a_ien) ien_q <= pwdata[7:0] & mirq_pkg::MIRQ_FLAG_MASK;
            if (wr & a_ctrl) begin
                gie_q <= pwdata[mirq_pkg::MIRQ_B_GIE];
                edge_q <= pwdata[mirq_pkg::MIRQ_B_EDGE_LO +: 2];
            end
        end
    end

    // stack level advances by one on each entry; software may rewrite it on return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_q <= mirq_pkg::MIRQ_STACK_RST;
            state_q <= mirq_pkg::MIRQ_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
            if (take) stack_q <= stack_q + mirq_pkg::MIRQ_STACK_STEP;
            else if (wr & a_stack) stack_q <= pwdata[2:0];
        end
    end

    // interrupt status, enable and line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= 4'h0;
            st_en_q <= 4'h0;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            if (wr & a_sten) st_en_q <= pwdata[3:0];
            irq_q <= |(st_d & ((wr & a_sten) ? pwdata[3:0] : st_en_q));
        end
    end

    // read mux
    wire [31:0] rdmux = a_flag ? {24'h0, flag_q} :
                        a_ien ? {24'h0, ien_q} :
                        a_ctrl ? {24'h0, gie_q, 2'b00, edge_q, 3'b000} :
                        a_stat ? {28'h0, st_q} :
                        a_sten ? {28'h0, st_en_q} :
                        a_stack ? {29'h0, stack_q} : mirq_pkg::MIRQ_RD_ZERO;

    // one wait state: pready rises the cycle after the access phase begins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            vreq_q <= 1'b0;
        end else if (clk_en) begin
            pready_q <= acc;
            pslverr_q <= acc & ~mapped;
            prdata_q <= rd ? rdmux : 32'h0000_0000;
            vreq_q <= (state_d == mirq_pkg::MIRQ_ENTRY);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign vector_req = vreq_q;
    assign vector_addr = mirq_pkg::MIRQ_VECTOR;
    assign stack_level = stack_q;
    assign irq = irq_q;

    // assertions
    sequence ev_seen_s;
        clk_en && |ev;
    endsequence
    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev_seen_s |=> ((flag_q & $past(ev)) == $past(ev))) else $error("event did not set flag");
    t1_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        t1_hit |=> flag_q[mirq_pkg::MIRQ_B_T1]) else $error("timer1 flag not set");
    no_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!gie_q && state_q == mirq_pkg::MIRQ_IDLE) |=> !vector_req) else $error("entry without global enable");
    req_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && pend && state_q == mirq_pkg::MIRQ_IDLE) |=> vector_req) else $error("pending not requested");
    disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == mirq_pkg::MIRQ_IDLE && (flag_q & ien_q) == 8'h00) |=> !vector_req) else $error("disabled source entered");
    vec_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        vector_req |-> vector_addr == 12'h008) else $error("wrong vector");
    stack_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        take |=> stack_level == $past(stack_q) + 3'h1) else $error("stack not advanced");
    flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !(wr && a_flag) && ev == 8'h00) |=> flag_q == $past(flag_q)) else $error("flag cleared by hardware");
    flag_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && a_flag && ev == 8'h00) |=> flag_q == ($past(pwdata[7:0]) & 8'h53)) else $error("flag write lost");
    ext1_a: assert property (@(posedge pclk) disable iff (!presetn)
        e1_hit |=> flag_q[mirq_pkg::MIRQ_B_EXT1]) else $error("ext1 flag not set");
    t0_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        t0_hit |=> flag_q[mirq_pkg::MIRQ_B_T0]) else $error("timer0 flag not set");
    e0_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        e0_hit |=> flag_q[mirq_pkg::MIRQ_B_EXT0]) else $error("ext0 flag not set");
    edge_res_a: assert property (@(posedge pclk) disable iff (!presetn)
        (edge_q == 2'b00) |-> !e0_hit) else $error("reserved edge code detected an edge");
    flag_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_q & ~mirq_pkg::MIRQ_FLAG_MASK) == 8'h00) else $error("unused flag bit set");

    // bus answer: one pulse per access; a frozen clock enable may stretch it
    sequence bus_take_s;
        acc;
    endsequence
    sequence bus_answer_s;
        pready && clk_en;
    endsequence
    rdy_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        bus_take_s |=> pready) else $error("no answer to access");
    rdy_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        bus_answer_s |=> !pready) else $error("answer longer than one cycle");
    err_unmap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && !mapped) |=> pslverr) else $error("unmapped access without error");
    err_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        (acc && mapped) |=> !pslverr) else $error("error on mapped access");
    rd_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !rd) |=> prdata == 32'h0000_0000) else $error("read data outside a read answer");

    // register writes land on the first access edge
    ien_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && a_ien) |=> ien_q == ($past(pwdata[7:0]) & 8'h53)) else $error("enable write lost");
    gie_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && a_ctrl) |=> gie_q == $past(pwdata[mirq_pkg::MIRQ_B_GIE])) else $error("global enable write lost");
    edge_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && a_ctrl) |=> edge_q == $past(pwdata[4:3])) else $error("edge field write lost");

    // vector entry: request, acknowledge, one wait cycle, back to idle
    sequence entry_ack_s;
        vector_req && vector_ack && clk_en;
    endsequence
    sequence entry_done_s;
        !vector_req && state_q == mirq_pkg::MIRQ_WAIT;
    endsequence
    entry_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        entry_ack_s |=> entry_done_s) else $error("acknowledge did not end request");
    entry_back_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == mirq_pkg::MIRQ_WAIT && clk_en) |=> state_q == mirq_pkg::MIRQ_IDLE)
        else $error("entry did not return to idle");
    take_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        take |=> !take) else $error("one acknowledge counted twice");
    req_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
        (vector_req && !vector_ack) |=> vector_req) else $error("request dropped before acknowledge");
    no_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !pend && state_q == mirq_pkg::MIRQ_IDLE) |=> !vector_req)
        else $error("entry with nothing pending");

    // stack moves only by entry or by software
    stack_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && !take && !(wr && a_stack)) |=> stack_level == $past(stack_q))
        else $error("stack moved without entry");
    stack_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && a_stack && !take) |=> stack_level == $past(pwdata[2:0])) else $error("stack write lost");

    // status and interrupt line; a clear takes effect only when nothing sets the bit
    st_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && a_stclr && !take && !pend && ev == 8'h00) |=> (st_q & $past(pwdata[3:0])) == 4'h0)
        else $error("status clear lost");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> irq == (|(st_q & st_en_q))) else $error("interrupt line disagrees with status");
endmodule // mirq_top
`default_nettype wire

/* File: rtl/mirq_pkg.sv */
// package of constants for the interrupt request logic
//
// Contract
// - second timer overflow sets its flag regardless of its enable
// - flag and enable both one make the processor take the vector
// - disabled source still sets its flag but causes no vector entry
// - each flag is set only by its own trigger, independent of enables; a software write of one to the flag register also sets it
// - ext0 on selected edge, ext1 on falling edge, timers on overflow
// - all sources share one vector at program address 8
// - global enable gates entry; entry loads vector and pushes stack one level
// - edge field: 01 rising, 10 falling, 11 both, 00 reserved
package mirq_pkg;
    // register byte offsets
    localparam logic [11:0] MIRQ_OFF_FLAG = 12'h000;
    localparam logic [11:0] MIRQ_OFF_IEN = 12'h004;
    localparam logic [11:0] MIRQ_OFF_CTRL = 12'h008;
    localparam logic [11:0] MIRQ_OFF_STAT = 12'h00C;
    localparam logic [11:0] MIRQ_OFF_ST_EN = 12'h010;
    localparam logic [11:0] MIRQ_OFF_ST_CLR = 12'h014;
    localparam logic [11:0] MIRQ_OFF_STACK = 12'h018;
    // flag and enable bit positions
    localparam int MIRQ_B_EXT0 = 0;
    localparam int MIRQ_B_EXT1 = 1;
    localparam int MIRQ_B_T0 = 4;
    localparam int MIRQ_B_T1 = 6;
    localparam logic [7:0] MIRQ_FLAG_MASK = 8'h53;
    // control register: global enable bit 7, edge field bits 4:3
    localparam int MIRQ_B_GIE = 7;
    localparam int MIRQ_B_EDGE_LO = 3;
    localparam logic [1:0] MIRQ_EDGE_RST = 2'h2;
    localparam logic [1:0] MIRQ_EDGE_RISE = 2'h1;
    localparam logic [1:0] MIRQ_EDGE_FALL = 2'h2;
    localparam logic [1:0] MIRQ_EDGE_BOTH = 2'h3;
    // vector and stack
    localparam logic [11:0] MIRQ_VECTOR = 12'h008;
    localparam logic [2:0] MIRQ_STACK_RST = 3'h7;
    localparam logic [2:0] MIRQ_STACK_STEP = 3'h1;
    localparam logic [31:0] MIRQ_RD_ZERO = 32'h0000_0000;
    // entry sequencer states, gray along idle->entry->wait
    typedef enum logic [1:0] {
        MIRQ_IDLE = 2'b00,
        MIRQ_ENTRY = 2'b01,
        MIRQ_WAIT = 2'b11
    } mirq_state_t;
endpackage

/* File: rtl/mirq_edge.sv */
// edge detector for one synchronised event line
`timescale 1ns/1ps
`default_nettype none
module mirq_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic sig_in,
    input wire logic [1:0] mode,
    output logic hit
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    wire rise = s2_q & ~s3_q;
    wire fall = ~s2_q & s3_q;

    // two stages of synchronisation, third holds the previous level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= sig_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // reserved code detects nothing
    assign hit = ce & (((mode == mirq_pkg::MIRQ_EDGE_RISE) & rise) |
                 ((mode == mirq_pkg::MIRQ_EDGE_FALL) & fall) |
                 ((mode == mirq_pkg::MIRQ_EDGE_BOTH) & (rise | fall)));
endmodule // mirq_edge
`default_nettype wire

/* File: verification/mirq_core_model.sv */
// processor core model that takes the shared interrupt vector
`timescale 1ns/1ps
`default_nettype none
module mirq_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] ack_delay,
    input wire logic vector_req,
    input wire logic [11:0] vector_addr,
    output logic vector_ack,
    output logic [7:0] entries,
    output logic [7:0] bad_addr
);
    logic [7:0] wait_q;
    // acknowledge after a set stall; a slow core only holds the one request longer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_ack <= 1'b0;
            wait_q <= 8'h00;
            entries <= 8'h00;
            bad_addr <= 8'h00;
        end else if (vector_req && !vector_ack) begin
            if (wait_q >= ack_delay) begin
                vector_ack <= 1'b1;
                wait_q <= 8'h00;
                entries <= entries + 8'h01;
                if (vector_addr !== 12'h008) bad_addr <= bad_addr + 8'h01;
            end else begin
                wait_q <= wait_q + 8'h01;
            end
        end else begin
            vector_ack <= 1'b0;
        end
    end
endmodule // mirq_core_model
`default_nettype wire

/* File: verification/mirq_test.sv */
// self-checking testbench of the interrupt request logic
`timescale 1ns/1ps
`default_nettype none
module mirq_test;
    localparam logic [11:0] A_FLAG = mirq_pkg::MIRQ_OFF_FLAG;
    localparam logic [11:0] A_IEN = mirq_pkg::MIRQ_OFF_IEN;
    localparam logic [11:0] A_CTRL = mirq_pkg::MIRQ_OFF_CTRL;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, clk_en;
    logic ext0_pin, ext1_pin, timer0_ovf, timer1_ovf, vector_ack, vector_req, irq;
    logic [11:0] paddr, vector_addr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] stack_level;
    logic [7:0] ack_delay, entries, bad_addr, n0, exp_f;
    logic [15:0] lfsr;
    int err_total, check_count, n;
    mirq_top u_mirq_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext0_pin(ext0_pin), .ext1_pin(ext1_pin), .timer0_ovf(timer0_ovf), .timer1_ovf(timer1_ovf),
        .vector_ack(vector_ack), .vector_req(vector_req), .vector_addr(vector_addr),
        .stack_level(stack_level), .irq(irq));
    mirq_core_model u_mirq_core_model (.pclk(pclk), .presetn(presetn), .ack_delay(ack_delay),
        .vector_req(vector_req), .vector_addr(vector_addr), .vector_ack(vector_ack), .entries(entries),
        .bad_addr(bad_addr));
    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // which edges of the first pin should raise its flag in a given mode
    function automatic logic exp_ext0(input logic [1:0] mode, input logic rising);
        return rising ? mode[0] : mode[1];
    endfunction
    // stack pointer wraps, so only the low bits of the entry count matter
    function automatic logic [2:0] exp_stack(input logic [7:0] e);
        return mirq_pkg::MIRQ_STACK_RST + e[2:0];
    endfunction
    // software priority: lowest flag position is served first
    function automatic logic [7:0] first_pending(input logic [7:0] p);
        return p & (~p + 8'h01);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 40) chk("pready", 32'h1, 32'h0);
    endtask
    // handler: enable and flag checked together, only the first pending source cleared
    task automatic service;
        logic [7:0] p;
        apb(1'b0, A_IEN, 32'h0);
        p = rd[7:0];
        apb(1'b0, A_FLAG, 32'h0);
        p = rd[7:0] & ~first_pending(p & rd[7:0]);
        apb(1'b1, A_FLAG, {24'h0, p});
    endtask
    // pins change together; eight cycles covers sync, edge detect and flag update
    task automatic drive(input logic [3:0] v);
        @(posedge pclk);
        {timer1_ovf, timer0_ovf, ext1_pin, ext0_pin} <= v;
        repeat (8) @(posedge pclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        tally_and_finish;
    end
    // main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {timer1_ovf, timer0_ovf, ext1_pin, ext0_pin} = 4'h0;
        clk_en = 1'b1;
        ack_delay = 8'h14;
        lfsr = 16'h471E;
        err_total = 0;
        check_count = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("stack_rst", {29'h0, mirq_pkg::MIRQ_STACK_RST}, {29'h0, stack_level});
        chk("vector_addr", 32'h8, {20'h0, vector_addr});
        apb(1'b0, A_FLAG, 32'h0);
        chk("flag_rst", 32'h0, rd);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            apb(1'b1, A_FLAG, {16'h0, lfsr});
            apb(1'b0, A_FLAG, 32'h0);
            chk("flag_rw", {24'h0, lfsr[7:0] & mirq_pkg::MIRQ_FLAG_MASK}, rd);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_rd", 32'h0, rd);
        // every edge mode of the first pin, global enable off
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, A_CTRL, m << mirq_pkg::MIRQ_B_EDGE_LO);
            apb(1'b1, A_FLAG, 32'h0);
            drive(4'h1);
            apb(1'b0, A_FLAG, 32'h0);
            chk("ext0_rise", {31'h0, exp_ext0(m[1:0], 1'b1)}, {31'h0, rd[0]});
            apb(1'b1, A_FLAG, 32'h0);
            drive(4'h0);
            apb(1'b0, A_FLAG, 32'h0);
            chk("ext0_fall", {31'h0, exp_ext0(m[1:0], 1'b0)}, {31'h0, rd[0]});
        end
        // second pin falls only; its event is masked, then unmasked, then cleared
        apb(1'b1, A_FLAG, 32'h0);
        apb(1'b1, mirq_pkg::MIRQ_OFF_ST_CLR, 32'hF);
        drive(4'h2);
        apb(1'b0, A_FLAG, 32'h0);
        chk("ext1_rise", 32'h0, {31'h0, rd[1]});
        drive(4'h0);
        apb(1'b0, A_FLAG, 32'h0);
        chk("ext1_fall", 32'h1, {31'h0, rd[1]});
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, mirq_pkg::MIRQ_OFF_ST_EN, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, mirq_pkg::MIRQ_OFF_ST_CLR, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq_off", 32'h0, {31'h0, irq});
        apb(1'b0, mirq_pkg::MIRQ_OFF_STAT, 32'h0);
        chk("stat_clr", 32'h0, {31'h0, rd[1]});
        // timer overflows with source enables off and global enable on
        n0 = entries;
        apb(1'b1, A_FLAG, 32'h0);
        apb(1'b1, A_IEN, 32'h0);
        apb(1'b1, A_CTRL, 32'h90);
        drive(4'h4);
        drive(4'hC);
        drive(4'h0);
        apb(1'b0, A_FLAG, 32'h0);
        chk("timer_flags", 32'h50, rd);
        chk("no_entry", {24'h0, n0}, {24'h0, entries});
        // enabling a flag already pending must still enter the vector
        apb(1'b1, A_IEN, 32'h40);
        n = 0;
        while (entries === n0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("late_entry", 32'h1, {31'h0, entries !== n0});
        apb(1'b1, A_CTRL, 32'h10);
        apb(1'b1, A_FLAG, 32'h0);
        // all enabled, global enable off, prompt core: nothing may enter
        ack_delay <= 8'h00;
        repeat (60) @(posedge pclk);
        n0 = entries;
        apb(1'b1, A_IEN, 32'h53);
        apb(1'b1, A_FLAG, 32'h53);
        repeat (20) @(posedge pclk);
        chk("gie_gate", {24'h0, n0}, {24'h0, entries});
        chk("req_low", 32'h0, {31'h0, vector_req});
        apb(1'b1, A_CTRL, 32'h90);
        apb(1'b1, A_CTRL, 32'h10);
        exp_f = 8'h53;
        repeat (4) begin
            exp_f = exp_f & ~first_pending(exp_f);
            service;
            apb(1'b0, A_FLAG, 32'h0);
            chk("service_order", {24'h0, exp_f}, rd);
        end
        repeat (60) @(posedge pclk);
        chk("gie_entry", 32'h1, {31'h0, entries !== n0});
        chk("stack_push", {29'h0, exp_stack(entries)}, {29'h0, stack_level});
        chk("vector_fetch", 32'h0, {24'h0, bad_addr});
        apb(1'b0, mirq_pkg::MIRQ_OFF_STACK, 32'h0);
        chk("stack_rd", {29'h0, exp_stack(entries)}, rd);
        // frozen clock enable: a whole overflow pulse must leave no trace
        clk_en <= 1'b0;
        drive(4'h4);
        drive(4'h0);
        clk_en <= 1'b1;
        apb(1'b0, A_FLAG, 32'h0);
        chk("freeze", 32'h0, rd);
        tally_and_finish;
    end
endmodule // mirq_test
`default_nettype wire
